// File: src/uart_async_pkg.sv
package uart_async_pkg;

    localparam int FRAME_W = 13;
    localparam int RX_BITS_W = 12;

    localparam logic [2:0] OFS_TX_BUF = 3'h0;
    localparam logic [2:0] OFS_RX_BUF = 3'h1;
    localparam logic [2:0] OFS_DIVISOR = 3'h2;
    localparam logic [2:0] OFS_MODE = 3'h3;
    localparam logic [2:0] OFS_CTRL0 = 3'h4;
    localparam logic [2:0] OFS_CTRL1 = 3'h5;
    localparam logic [2:0] OFS_SHARED = 3'h6;

    localparam logic [2:0] MODE_ASYNC7 = 3'h4;
    localparam logic [2:0] MODE_ASYNC8 = 3'h5;
    localparam logic [2:0] MODE_ASYNC9 = 3'h6;

    localparam logic [1:0] SRC_DIV1 = 2'h0;
    localparam logic [1:0] SRC_DIV8 = 2'h1;
    localparam logic [1:0] SRC_DIV32 = 2'h2;
    localparam logic [2:0] PRESCALE8_LAST = 3'h7;
    localparam logic [4:0] PRESCALE32_LAST = 5'h1f;

    localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0] OVERSAMPLE_MID = 4'h7;

    localparam logic [3:0] LEN7 = 4'h7;
    localparam logic [3:0] LEN8 = 4'h8;
    localparam logic [3:0] LEN9 = 4'h9;
    localparam logic [8:0] MASK7 = 9'h07f;
    localparam logic [8:0] MASK8 = 9'h0ff;
    localparam logic [8:0] MASK9 = 9'h1ff;

    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] SHARED_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET = 8'h00;

    typedef struct packed {
        logic reserved7;
        logic parity_enable;
        logic parity_odd_even_select;
        logic stop_bit_count;
        logic clock_source_direction;
        logic [2:0] serial_mode_field;
    } mode_type;

    typedef struct packed {
        logic bit_order_select;
        logic clock_polarity_select;
        logic open_drain_select;
        logic reserved4;
        logic shift_register_empty_flag;
        logic reserved2;
        logic [1:0] divisor_source_select;
    } ctrl0_type;

    typedef struct packed {
        logic [3:0] reserved;
        logic rx_complete_flag;
        logic rx_enable_bit;
        logic tx_buffer_empty_flag;
        logic tx_enable_bit;
    } ctrl1_type;

    typedef struct packed {
        logic [1:0] reserved;
        logic ch1_shared_pin_direction;
        logic ch1_second_output_select;
        logic reserved3;
        logic continuous_rx_mode;
        logic ch1_tx_irq_source;
        logic ch0_tx_irq_source;
    } shared_type;

    typedef struct packed {
        logic sum_error;
        logic parity_error;
        logic framing_flag;
        logic overrun_flag;
        logic [2:0] reserved;
        logic [8:0] data;
    } rx_word_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b11
    } rx_state_type;

    typedef enum logic {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_type;

endpackage

// File: src/uart_pin_sync.sv
`timescale 1ns/1ps
module uart_pin_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);

    // Idle lines rest high, so the chain resets high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            level_reg <= '1;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= (agree & s3_reg) | (~agree & level_reg);
        end
    end

    assign level = level_reg;
endmodule // uart_pin_sync

// File: src/uart_bit_clock.sv
`timescale 1ns/1ps
module uart_bit_clock (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] src_sel,
    input wire logic use_ext,
    input wire logic ext_level,
    input wire logic [7:0] divisor,
    output logic tick16
);
    logic [4:0] pre_reg;
    logic ext_prev_reg;
    logic [7:0] div_reg;
    logic tick_reg;

    wire ext_rise = ext_level && !ext_prev_reg;
    wire int_tick = (src_sel == uart_async_pkg::SRC_DIV1) ||
        (src_sel == uart_async_pkg::SRC_DIV8 &&
         pre_reg[2:0] == uart_async_pkg::PRESCALE8_LAST) ||
        (src_sel == uart_async_pkg::SRC_DIV32 &&
         pre_reg == uart_async_pkg::PRESCALE32_LAST);
    // Selection 11 yields no internal ticks at all
    wire src_tick = run && (use_ext ? ext_rise : int_tick);
    wire div_zero = (div_reg == 8'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg <= 5'h00;
            ext_prev_reg <= 1'b1;
            div_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            pre_reg <= pre_reg + 5'h01;
            ext_prev_reg <= ext_level;
            tick_reg <= src_tick && div_zero;
            if (!run) begin
                div_reg <= divisor;
            end else if (src_tick) begin
                div_reg <= div_zero ? divisor : div_reg - 8'h01;
            end
        end
    end

    assign tick16 = tick_reg;

    a_divisor_reload: assert property (@(posedge clk) disable iff (!rst_n)
        src_tick && div_zero |=> div_reg == $past(divisor))
        else $error("divisor counter did not reload");
endmodule // uart_bit_clock

// File: src/uart_async_channel.sv
// Behaviour
// - A frame has one start bit and seven, eight or nine data bits.
// - One or two stop bits end the frame, as configured.
// - Optional odd or even parity bit follows the data.
// - Internal bit rate is prescaled clock over 16 times divisor plus one.
// - External bit rate is clock pin rate over 16 times divisor plus one.
// - Only channel 0 may use the external bit clock.
// - Divisor source: 00 undivided, 01 divide by 8, 10 by 32.
// - Sending starts when transmit is enabled and the buffer holds data.
// - Receiving starts when receive is enabled and a start bit arrives.
// - Transmit interrupt on buffer-to-shifter move or on send completion.
// - Receive interrupt when a character enters the receive buffer.
// - Overrun when buffer unread by the bit before the last stop.
// - On overrun buffer is undefined and no receive interrupt is raised.
// - Framing error when the configured stop bits are missing.
// - Parity error when ones count disagrees with odd or even setting.
// - Summary error flag is set when any error flag is set.
// - Mode field 100, 101, 110 selects 7, 8, 9 bit asynchronous mode.
// - Bit order choice applies only to eight bit characters.
// - Buffers use bits 0-6, 0-7 or 0-8 by character length.
// - Output pin idles high, or floats in open-drain mode.
// - Channel 1 shared pin transmits when direction bit 1, receives when 0.
// - Channel 1 second output pin carries transmit data when selected.
// - Shift register empty flag is 0 while sending, 1 when done.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module uart_async_channel #(
    parameter bit CHANNEL_ID = 1'b0
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [2:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic SERIAL_INPUT_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    output logic SERIAL_OUTPUT_PIN,
    output logic SERIAL_OUTPUT_PIN_EN,
    output logic CH1_SECOND_TX_PIN,
    output logic CH1_SECOND_TX_PIN_EN,
    output logic TX_IRQ,
    output logic RX_IRQ
);
    uart_async_pkg::mode_type mode_reg;
    uart_async_pkg::ctrl0_type ctrl0_reg;
    uart_async_pkg::ctrl1_type ctrl1_reg;
    uart_async_pkg::shared_type shared_reg;
    logic [7:0] divisor_reg;

    uart_async_pkg::tx_state_type tx_state_reg;
    logic [8:0] tx_buf_reg;
    logic tx_empty_reg;
    logic [uart_async_pkg::FRAME_W-1:0] tx_shift_reg;
    logic [3:0] tx_bits_reg;
    logic [3:0] tx_phase_reg;

    uart_async_pkg::rx_state_type rx_state_reg;
    logic [uart_async_pkg::RX_BITS_W-1:0] rx_bits_reg;
    logic [3:0] rx_phase_reg;
    logic [3:0] rx_idx_reg;
    logic rx_ov_pend_reg;
    logic [8:0] rx_buf_reg;
    logic rx_full_reg;
    logic overrun_reg;
    logic framing_reg;
    logic parity_err_reg;

    logic [15:0] rdata_reg;
    logic pin_reg;
    logic pin_en_reg;
    logic pin2_reg;
    logic pin2_en_reg;
    logic tx_irq_reg;
    logic rx_irq_reg;

    logic [1:0] pins_sync;
    logic tick16;

    // Bus decode
    wire wr_tx = WR && ADDR == uart_async_pkg::OFS_TX_BUF;
    wire wr_div = WR && ADDR == uart_async_pkg::OFS_DIVISOR;
    wire wr_mode = WR && ADDR == uart_async_pkg::OFS_MODE;
    wire wr_c0 = WR && ADDR == uart_async_pkg::OFS_CTRL0;
    wire wr_c1 = WR && ADDR == uart_async_pkg::OFS_CTRL1;
    wire wr_sh = WR && ADDR == uart_async_pkg::OFS_SHARED;
    wire rd_rx = RD && ADDR == uart_async_pkg::OFS_RX_BUF;

    // Frame format
    wire [2:0] smode = mode_reg.serial_mode_field;
    wire is7 = smode == uart_async_pkg::MODE_ASYNC7;
    wire is8 = smode == uart_async_pkg::MODE_ASYNC8;
    wire is9 = smode == uart_async_pkg::MODE_ASYNC9;
    wire uart_mode = is7 || is8 || is9;
    wire [3:0] len = is7 ? uart_async_pkg::LEN7 :
        (is8 ? uart_async_pkg::LEN8 : uart_async_pkg::LEN9);
    wire [8:0] mask = is7 ? uart_async_pkg::MASK7 :
        (is8 ? uart_async_pkg::MASK8 : uart_async_pkg::MASK9);
    wire par_en = mode_reg.parity_enable;
    wire par_even = mode_reg.parity_odd_even_select;
    wire stop2 = mode_reg.stop_bit_count;
    // Reversal only for 8-bit; stray setting is ignored otherwise
    wire msb_first = is8 && ctrl0_reg.bit_order_select;
    wire [3:0] rx_total = len + {3'h0, par_en} + 4'h1 + {3'h0, stop2};
    wire [3:0] tx_total = rx_total + 4'h1;
    wire use_ext = (CHANNEL_ID == 1'b0) &&
        mode_reg.clock_source_direction;
    wire irq_src = CHANNEL_ID ? shared_reg.ch1_tx_irq_source :
        shared_reg.ch0_tx_irq_source;
    wire pin_dir = shared_reg.ch1_shared_pin_direction;

    function automatic logic [8:0] order_fix(logic [8:0] d, logic rev);
        logic [8:0] r;
        r = d;
        if (rev) begin
            r[8] = 1'b0;
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7-i];
            end
        end
        return r;
    endfunction

    uart_pin_sync #(.W(2)) pin_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .raw({SERIAL_CLOCK_PIN, SERIAL_INPUT_PIN}),
        .level(pins_sync)
    );

    uart_bit_clock bit_clock (
        .clk(CLK),
        .rst_n(RST_N),
        .run(uart_mode),
        .src_sel(ctrl0_reg.divisor_source_select),
        .use_ext(use_ext),
        .ext_level(pins_sync[1]),
        .divisor(divisor_reg),
        .tick16(tick16)
    );

    // Transmitter
    wire [8:0] tx_data = order_fix(tx_buf_reg & mask, msb_first);
    wire tx_parity = ^tx_data ^ ~par_even;
    logic [uart_async_pkg::FRAME_W-1:0] tx_frame;
    always_comb begin
        tx_frame = '1;
        tx_frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(len)) begin
                tx_frame[i+1] = tx_data[i];
            end
        end
        if (par_en) begin
            tx_frame[len+4'h1] = tx_parity;
        end
    end

    wire tx_sending = tx_state_reg == uart_async_pkg::TX_SEND;
    wire tx_bit_end = tx_sending && tick16 &&
        tx_phase_reg == uart_async_pkg::OVERSAMPLE_LAST;
    wire tx_last = tx_bit_end && tx_bits_reg == 4'h1;
    wire tx_load = uart_mode && ctrl1_reg.tx_enable_bit && !tx_empty_reg &&
        tick16 && (!tx_sending || tx_last);
    wire tx_level = tx_sending ? tx_shift_reg[0] : 1'b1;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_state_reg <= uart_async_pkg::TX_IDLE;
            tx_shift_reg <= '1;
            tx_bits_reg <= 4'h0;
            tx_phase_reg <= 4'h0;
        end else if (tx_load) begin
            tx_state_reg <= uart_async_pkg::TX_SEND;
            tx_shift_reg <= tx_frame;
            tx_bits_reg <= tx_total;
            tx_phase_reg <= 4'h0;
        end else if (tx_sending && tick16) begin
            tx_phase_reg <= tx_phase_reg + 4'h1;
            if (tx_bit_end) begin
                tx_shift_reg <= {1'b1, tx_shift_reg[uart_async_pkg::FRAME_W-1:1]};
                tx_bits_reg <= tx_bits_reg - 4'h1;
                if (tx_last) begin
                    tx_state_reg <= uart_async_pkg::TX_IDLE;
                end
            end
        end
    end

    // Receiver
    wire rx_line = (CHANNEL_ID && pin_dir) ? 1'b1 : pins_sync[0];
    wire rx_idle = rx_state_reg == uart_async_pkg::RX_IDLE;
    wire rx_begin = rx_idle && uart_mode && ctrl1_reg.rx_enable_bit &&
        tick16 && !rx_line;
    wire rx_mid = rx_state_reg == uart_async_pkg::RX_START && tick16 &&
        rx_phase_reg == uart_async_pkg::OVERSAMPLE_MID;
    wire rx_sample = rx_state_reg == uart_async_pkg::RX_BITS && tick16 &&
        rx_phase_reg == uart_async_pkg::OVERSAMPLE_LAST;
    wire rx_done = rx_sample && rx_idx_reg == rx_total - 4'h1;
    wire rx_pre_stop = rx_sample && rx_idx_reg == rx_total - 4'h2;
    logic [uart_async_pkg::RX_BITS_W-1:0] rx_cur;
    always_comb begin
        rx_cur = rx_bits_reg;
        rx_cur[rx_idx_reg] = rx_line;
    end
    wire [8:0] rx_raw = rx_cur[8:0] & mask;
    wire [8:0] rx_data = order_fix(rx_raw, msb_first);
    wire rx_par_bit = rx_cur[len];
    wire [3:0] stop_pos = len + {3'h0, par_en};
    wire rx_frame_bad = !rx_cur[stop_pos] ||
        (stop2 && !rx_cur[stop_pos+4'h1]);
    wire rx_par_bad = par_en && (^rx_raw ^ rx_par_bit ^ ~par_even);
    wire ov_event = rx_done && rx_ov_pend_reg;
    wire rx_store = rx_done && !ov_event;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_state_reg <= uart_async_pkg::RX_IDLE;
            rx_bits_reg <= '0;
            rx_phase_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
            rx_ov_pend_reg <= 1'b0;
        end else if (rx_begin) begin
            rx_state_reg <= uart_async_pkg::RX_START;
            rx_phase_reg <= 4'h0;
            rx_ov_pend_reg <= 1'b0;
        end else if (rx_mid) begin
            // A glitch shorter than half a bit is not a start bit
            rx_state_reg <= rx_line ? uart_async_pkg::RX_IDLE :
                uart_async_pkg::RX_BITS;
            rx_phase_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
        end else if (!rx_idle && tick16) begin
            rx_phase_reg <= rx_phase_reg + 4'h1;
            if (rx_sample) begin
                rx_bits_reg <= rx_cur;
                rx_idx_reg <= rx_idx_reg + 4'h1;
                if (rx_pre_stop) begin
                    rx_ov_pend_reg <= rx_full_reg;
                end
                if (rx_done) begin
                    rx_state_reg <= uart_async_pkg::RX_IDLE;
                end
            end
        end
    end

    // Receive buffer and flags; set wins over the read clear
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_buf_reg <= 9'h000;
            rx_full_reg <= 1'b0;
            overrun_reg <= 1'b0;
            framing_reg <= 1'b0;
            parity_err_reg <= 1'b0;
        end else begin
            rx_full_reg <= rx_store || (rx_full_reg && !rd_rx);
            if (!ctrl1_reg.rx_enable_bit) begin
                overrun_reg <= 1'b0;
                framing_reg <= 1'b0;
                parity_err_reg <= 1'b0;
            end else if (ov_event) begin
                // Buffer left as it was; its content counts as undefined
                overrun_reg <= 1'b1;
            end else if (rx_store) begin
                rx_buf_reg <= rx_data;
                framing_reg <= rx_frame_bad;
                parity_err_reg <= rx_par_bad;
            end
        end
    end

    // Register file
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_reg <= uart_async_pkg::MODE_RESET;
            ctrl0_reg <= uart_async_pkg::CTRL0_RESET;
            ctrl1_reg <= uart_async_pkg::CTRL1_RESET;
            shared_reg <= uart_async_pkg::SHARED_RESET;
            divisor_reg <= uart_async_pkg::DIVISOR_RESET;
            tx_buf_reg <= 9'h000;
            tx_empty_reg <= 1'b1;
        end else begin
            if (wr_mode) mode_reg <= WDATA[7:0];
            if (wr_c0) ctrl0_reg <= WDATA[7:0];
            if (wr_c1) ctrl1_reg <= WDATA[7:0];
            if (wr_sh) shared_reg <= WDATA[7:0];
            if (wr_div) divisor_reg <= WDATA[7:0];
            if (wr_tx) tx_buf_reg <= WDATA[8:0];
            // A fresh write keeps the buffer marked full
            tx_empty_reg <= !wr_tx && (tx_empty_reg || tx_load);
        end
    end

    wire uart_mode_sum = overrun_reg || framing_reg || parity_err_reg;
    wire [15:0] rx_word = {uart_mode_sum, parity_err_reg, framing_reg,
        overrun_reg, 3'h0, rx_buf_reg};
    wire [7:0] c0_word = {ctrl0_reg[7:4], !tx_sending, 1'b0,
        ctrl0_reg[1:0]};
    wire [7:0] c1_word = {4'h0, rx_full_reg, ctrl1_reg.rx_enable_bit,
        tx_empty_reg, ctrl1_reg.tx_enable_bit};
    wire [15:0] rd_mux =
        ADDR == uart_async_pkg::OFS_RX_BUF ? rx_word :
        ADDR == uart_async_pkg::OFS_MODE ? {8'h00, mode_reg} :
        ADDR == uart_async_pkg::OFS_CTRL0 ? {8'h00, c0_word} :
        ADDR == uart_async_pkg::OFS_CTRL1 ? {8'h00, c1_word} :
        ADDR == uart_async_pkg::OFS_SHARED ? {8'h00, shared_reg} : 16'h0000;

    // Pins and events
    wire drive1 = uart_mode && (CHANNEL_ID == 1'b0 || pin_dir);
    wire drive2 = CHANNEL_ID && uart_mode &&
        shared_reg.ch1_second_output_select;
    wire od = ctrl0_reg.open_drain_select;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_reg <= 16'h0000;
            pin_reg <= 1'b1;
            pin_en_reg <= 1'b0;
            pin2_reg <= 1'b1;
            pin2_en_reg <= 1'b0;
            tx_irq_reg <= 1'b0;
            rx_irq_reg <= 1'b0;
        end else begin
            rdata_reg <= RD ? rd_mux : 16'h0000;
            pin_reg <= od ? 1'b0 : tx_level;
            pin_en_reg <= drive1 && (!od || !tx_level);
            pin2_reg <= od ? 1'b0 : tx_level;
            pin2_en_reg <= drive2 && (!od || !tx_level);
            tx_irq_reg <= irq_src ? tx_last : tx_load;
            rx_irq_reg <= rx_store;
        end
    end

    assign RDATA = rdata_reg;
    assign SERIAL_OUTPUT_PIN = pin_reg;
    assign SERIAL_OUTPUT_PIN_EN = pin_en_reg;
    assign CH1_SECOND_TX_PIN = pin2_reg;
    assign CH1_SECOND_TX_PIN_EN = pin2_en_reg;
    assign TX_IRQ = tx_irq_reg;
    assign RX_IRQ = rx_irq_reg;

    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_tx_start_cond: assert property ($rose(tx_sending) |->
        $past(ctrl1_reg.tx_enable_bit) && $past(!tx_empty_reg))
        else $error("transmit started without enable and data");
    a_rx_irq_store: assert property (rx_store |=>
        RX_IRQ && rx_full_reg) else $error("receive interrupt missing");
    a_rx_begin_en: assert property ($rose(rx_state_reg ==
        uart_async_pkg::RX_START) |-> $past(ctrl1_reg.rx_enable_bit))
        else $error("receive began while disabled");
    a_tx_irq_load: assert property (tx_load && !irq_src |=>
        TX_IRQ ##1 !TX_IRQ) else $error("transmit load interrupt wrong");
    a_rx_irq_overrun: assert property (ov_event &&
        ctrl1_reg.rx_enable_bit |=> !RX_IRQ && overrun_reg)
        else $error("overrun raised receive interrupt");
    a_rx_full_set: assert property (rx_store |=> rx_full_reg [*2] or
        (rx_full_reg ##1 $past(rd_rx))) else $error("complete flag lost");
    a_sum_flag: assert property (rd_rx |=> RDATA[15] ==
        (RDATA[14] || RDATA[13] || RDATA[12])) else $error("sum flag wrong");
    a_idle_high: assert property (uart_mode && !tx_sending && !od &&
        drive1 ##1 uart_mode |-> SERIAL_OUTPUT_PIN && SERIAL_OUTPUT_PIN_EN)
        else $error("idle output not high");
    a_stop_level: assert property (tx_sending && (tx_bits_reg == 4'h1 ||
        (stop2 && tx_bits_reg == 4'h2)) |-> tx_shift_reg[0])
        else $error("stop bit not high");
    a_framing_set: assert property (rx_store &&
        !rx_cur[stop_pos] && ctrl1_reg.rx_enable_bit |=> framing_reg)
        else $error("framing error missed");
    a_empty_flag: assert property (tx_load && !wr_tx |=>
        !c0_word[3] && tx_empty_reg)
        else $error("empty flags wrong after load");

    c_tx_done: cover property (tx_last);
    c_rx_store: cover property (rx_store);
    c_overrun: cover property (ov_event);
    c_parity_err: cover property (rx_store && rx_par_bad);
endmodule // uart_async_channel

// File: dv/remote_uart.sv
`timescale 1ns/1ps
module remote_uart #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    logic [11:0] cap;
    int frames = 0;
    initial line_out = 1'b1;
    // Twelve slots; slots after the stop bits read the idle level
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int k = 0; k < 12; k++) begin
            repeat (BIT_CYC) @(posedge clk);
            cap[k] = line_in;
        end
        frames++;
    end
    task automatic send(input logic [11:0] bits, input int n);
        for (int k = -1; k < n; k++) begin
            line_out <= (k < 0) ? 1'b0 : bits[k];
            repeat (BIT_CYC) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask
endmodule // remote_uart

// File: dv/async_serial_uart_mode_tb.sv
`timescale 1ns/1ps
module async_serial_uart_mode_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [15:0] got;
    logic pin, pin_en, rxd, tx_irq, rx_irq, p;
    logic [7:0] cfg [3] = '{8'h74, 8'h05, 8'h46};
    logic [11:0] expf;
    logic [8:0] txd = 9'h1a5;
    logic ext_clk = 1'b0;
    int fail_count = 0;
    int checked = 0;
    int tx_irqs = 0;
    int rx_irqs = 0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (tx_irq === 1'b1) tx_irqs++;
        if (rx_irq === 1'b1) rx_irqs++;
    end
    uart_async_channel #(.CHANNEL_ID(1'b0)) DUT (.CLK(clk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SERIAL_INPUT_PIN(rxd), .SERIAL_CLOCK_PIN(ext_clk),
        .SERIAL_OUTPUT_PIN(pin), .SERIAL_OUTPUT_PIN_EN(pin_en),
        .CH1_SECOND_TX_PIN(), .CH1_SECOND_TX_PIN_EN(), .TX_IRQ(tx_irq),
        .RX_IRQ(rx_irq));
    // Divisor 0 on the undivided source: 16 clocks per bit
    remote_uart peer (.clk(clk), .line_in(pin_en ? pin : 1'b1),
        .line_out(rxd));
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e, a);
        checked++;
        if (a !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, e, a);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] e,
        input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(what, e, rdata);
    endtask
    task automatic rx_frame(input logic [11:0] bits, input int irqs);
        peer.send(bits, 10);
        repeat (40) @(posedge clk);
        check("rx irq count", 16'(irqs), 16'(rx_irqs));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(uart_async_pkg::OFS_CTRL1, 16'h0002, "ctrl1");
        rd_reg(uart_async_pkg::OFS_TX_BUF, 16'h0000, "tx buffer");
        rd_reg(3'h7, 16'h0000, "unmapped");
        wr_reg(uart_async_pkg::OFS_MODE, 16'h0005);
        wr_reg(uart_async_pkg::OFS_TX_BUF, 16'h00a5);
        repeat (300) @(posedge clk);
        check("idle frames", 16'h0000, 16'(peer.frames));
        $display("test idle done");
        for (int i = 0; i < 3; i++) begin
            wr_reg(uart_async_pkg::OFS_MODE, {8'h00, cfg[i]});
            wr_reg(uart_async_pkg::OFS_TX_BUF, 16'h01a5);
            wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0001);
            for (int c = 0; c < 600 && peer.frames <= i; c++) @(posedge clk);
            check("frame count", 16'(i + 1), 16'(peer.frames));
            if (peer.frames <= i) test_done();
            wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0000);
            expf = 12'hfff;
            p = ~cfg[i][5];
            for (int k = 0; k < 7 + i; k++) begin
                expf[k] = txd[k];
                p = p ^ expf[k];
            end
            if (cfg[i][6]) expf[7 + i] = p;
            check("tx frame", {4'h0, expf}, {4'h0, peer.cap});
            check("tx irq count", 16'(i + 1), 16'(tx_irqs));
            rd_reg(uart_async_pkg::OFS_CTRL0, 16'h0008, "ctrl0");
            $display("test tx mode %0d done", i);
        end
        wr_reg(uart_async_pkg::OFS_MODE, 16'h0065);
        wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0004);
        rx_frame(12'h25a, 1);
        // Left unread so the next character overruns
        rx_frame(12'h233, 1);
        rd_reg(uart_async_pkg::OFS_RX_BUF, 16'h905a, "overrun");
        wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0000);
        wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0004);
        rx_frame(12'h15a, 2);
        rd_reg(uart_async_pkg::OFS_RX_BUF, 16'he05a, "errors");
        $display("test rx done");
        // External source: no tick until the clock pin rises
        wr_reg(uart_async_pkg::OFS_MODE, 16'h000d);
        wr_reg(uart_async_pkg::OFS_CTRL1, 16'h0001);
        wr_reg(uart_async_pkg::OFS_TX_BUF, 16'h00a5);
        repeat (50) @(posedge clk);
        check("ext idle irqs", 16'h0003, 16'(tx_irqs));
        ext_clk <= 1'b1;
        repeat (12) @(posedge clk);
        check("ext tick irqs", 16'h0004, 16'(tx_irqs));
        $display("test ext clock done");
        test_done();
    end
endmodule // async_serial_uart_mode_tb
